//--- include/pfcs_map.svh
`ifndef PFCS_MAP_SVH
`define PFCS_MAP_SVH
// system clock
`define PFCS_CLK_NS        25
// write strobe low time and read access time, in ns
`define PFCS_WP_NS         40
`define PFCS_RD_NS         90
`define PFCS_WP_CYC        ((`PFCS_WP_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
`define PFCS_RD_CYC        ((`PFCS_RD_NS + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
// longest internal byte program, in us
`define PFCS_PROG_US       20
`define PFCS_PROG_CYC      ((`PFCS_PROG_US * 1000 + `PFCS_CLK_NS - 1) / `PFCS_CLK_NS)
// unlock pattern and command codes
`define PFCS_UNLOCK_ADDR1  21'h05555
`define PFCS_UNLOCK_ADDR2  21'h02aaa
`define PFCS_UNLOCK_DATA1  8'haa
`define PFCS_UNLOCK_DATA2  8'h55
`define PFCS_PROG_CODE     8'ha0
`define PFCS_ERASE_CODE    8'h80
`define PFCS_SECT_CODE     8'h30
`define PFCS_BLOCK_CODE    8'h50
`define PFCS_CHIP_CODE     8'h10
`define PFCS_ERASED        8'hff
// erase address granularity and status bit positions
`define PFCS_SECT_LSB      12
`define PFCS_BLOCK_LSB     16
`define PFCS_POLL_BIT      7
`define PFCS_TOGGLE_BIT    6
// bus cycles per sequence
`define PFCS_PROG_STEPS    4
`define PFCS_ERASE_STEPS   6
`endif

//--- include/pfcs_pkg.sv
`default_nettype none
package pfcs_pkg;
   typedef enum logic [2:0] {OP_READ, OP_PROG, OP_SECT, OP_BLOCK, OP_CHIP} pfcs_op_type;
   typedef enum logic [2:0] {SEQ_IDLE, SEQ_READ, SEQ_WRITE, SEQ_POLL, SEQ_CONFIRM}
      pfcs_seq_state_type;
   typedef enum logic [2:0] {CYC_IDLE, CYC_SETUP, CYC_STROBE, CYC_HOLD, CYC_DONE}
      pfcs_cyc_state_type;
endpackage : pfcs_pkg
`default_nettype wire

//--- include/pfcs_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pfcs_cyc_if #(parameter int ADDR_W = 21) ();
   logic              req;
   logic              wr;
   logic [ADDR_W-1:0] addr;
   logic [7:0]        wdata;
   logic              done;
   logic [7:0]        rdata;
   modport master (output req, output wr, output addr, output wdata, input done, input rdata);
   modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : pfcs_cyc_if
`default_nettype wire

//--- rtl/pfcs_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "pfcs_map.svh"
module pfcs_bus_cycle import pfcs_pkg::*; #(
   parameter int ADDR_W = 21
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst_n,
   pfcs_cyc_if.engine             cyc,
   output logic                   o_ce_n,
   output logic                   o_oe_n,
   output logic                   o_we_n,
   output logic [ADDR_W-1:0]      o_addr,
   input  wire logic [7:0]        i_dq,
   output logic [7:0]             o_dq,
   output logic                   o_dq_oe
);
   pfcs_cyc_state_type state_reg, state_next;
   logic [3:0]         cnt_reg, cnt_next;
   logic               wr_reg, wr_next;
   logic               ce_n_reg, ce_n_next, oe_n_reg, oe_n_next, we_n_reg, we_n_next;
   logic [ADDR_W-1:0]  addr_reg, addr_next;
   logic [7:0]         dq_reg, dq_next, rdata_reg, rdata_next;
   logic               dq_oe_reg, dq_oe_next;
   logic [7:0]         sync1_reg, sync2_reg;

   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      wr_next    = wr_reg;
      ce_n_next  = ce_n_reg;
      oe_n_next  = oe_n_reg;
      we_n_next  = we_n_reg;
      addr_next  = addr_reg;
      dq_next    = dq_reg;
      dq_oe_next = dq_oe_reg;
      rdata_next = rdata_reg;
      unique case (state_reg)
         CYC_IDLE: if (cyc.req) begin
            ce_n_next  = 1'b0;
            oe_n_next  = cyc.wr;
            wr_next    = cyc.wr;
            addr_next  = cyc.addr;
            dq_next    = cyc.wdata;
            dq_oe_next = cyc.wr;
            state_next = CYC_SETUP;
         end
         CYC_SETUP: begin
            // address settles under chip select before the write strobe falls; on reads output enable fell with chip select
            we_n_next  = !wr_reg;
            cnt_next   = wr_reg ? 4'(`PFCS_WP_CYC - 1) : 4'(`PFCS_RD_CYC + 1);
            state_next = CYC_STROBE;
         end
         CYC_STROBE: if (cnt_reg == 4'h0) begin
            if (wr_reg) begin
               we_n_next  = 1'b1;
               state_next = CYC_HOLD;
            end else begin
               rdata_next = sync2_reg;
               ce_n_next  = 1'b1;
               oe_n_next  = 1'b1;
               state_next = CYC_DONE;
            end
         end else begin
            cnt_next = cnt_reg - 4'h1;
         end
         CYC_HOLD: begin
            ce_n_next  = 1'b1;
            state_next = CYC_DONE;
         end
         CYC_DONE: begin
            dq_oe_next = 1'b0;
            state_next = CYC_IDLE;
         end
         default: state_next = CYC_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_reg <= CYC_IDLE;
         cnt_reg   <= 4'h0;
         wr_reg    <= 1'b0;
         ce_n_reg  <= 1'b1;
         oe_n_reg  <= 1'b1;
         we_n_reg  <= 1'b1;
         addr_reg  <= '0;
         dq_reg    <= 8'h00;
         dq_oe_reg <= 1'b0;
         rdata_reg <= 8'h00;
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
         wr_reg    <= wr_next;
         ce_n_reg  <= ce_n_next;
         oe_n_reg  <= oe_n_next;
         we_n_reg  <= we_n_next;
         addr_reg  <= addr_next;
         dq_reg    <= dq_next;
         dq_oe_reg <= dq_oe_next;
         rdata_reg <= rdata_next;
         sync1_reg <= i_dq;
         sync2_reg <= sync1_reg;
      end
   end

   assign cyc.done  = (state_reg == CYC_DONE);
   assign cyc.rdata = rdata_reg;
   assign o_ce_n    = ce_n_reg;
   assign o_oe_n    = oe_n_reg;
   assign o_we_n    = we_n_reg;
   assign o_addr    = addr_reg;
   assign o_dq      = dq_reg;
   assign o_dq_oe   = dq_oe_reg;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   we_under_ce_a: assert property (!o_we_n |-> !o_ce_n)
      else $error("write strobe low without chip select");
   no_contend_a: assert property (!o_oe_n |-> !o_dq_oe)
      else $error("data driven while output enable low");
   we_width_a: assert property ($fell(o_we_n) |-> !o_we_n [*2] ##1 (o_we_n && !o_ce_n))
      else $error("write strobe width wrong");
   data_hold_a: assert property ($rose(o_we_n) |-> o_dq_oe && $stable(o_dq) ##1 o_dq_oe)
      else $error("data not held over strobe rise");
   deselect_a: assert property (cyc.done |-> o_ce_n && o_we_n && o_oe_n)
      else $error("chip still selected after cycle");
endmodule : pfcs_bus_cycle
`default_nettype wire

//--- rtl/pfcs_sequencer.sv
// How it works
// - write cycles pull the write strobe low only while chip select is low.
// - the user must erase the sector before programming bytes in it.
// - program is three unlock writes plus one address and data write.
// - sector erase is six writes ending with 30h at a 4 KB sector.
// - block erase is six writes ending with 50h at a 64 KB block.
// - chip erase is six writes ending with 10h at 5555h.
// - apparent completion is confirmed by two more reads of the location.
`timescale 1ns/1ps
`default_nettype none
`include "pfcs_map.svh"
module pfcs_sequencer import pfcs_pkg::*; #(
   parameter int ADDR_W        = 21,
   parameter int ERASE_TMO_CYC = 8000000
) (
   input  wire logic              I_SYS_CLK,
   input  wire logic              I_RST_N,
   input  wire logic              I_CMD_VALID,
   input  wire pfcs_op_type       I_CMD_OP,
   input  wire logic [ADDR_W-1:0] I_CMD_ADDR,
   input  wire logic [7:0]        I_CMD_DATA,
   output logic                   O_CMD_READY,
   output logic                   O_DONE,
   output logic                   O_ERROR,
   output logic [7:0]             O_RD_DATA,
   output logic                   O_FLASH_CE_N,
   output logic                   O_FLASH_OE_N,
   output logic                   O_FLASH_WE_N,
   output logic [ADDR_W-1:0]      O_FLASH_ADDR,
   input  wire logic [7:0]        I_FLASH_DQ,
   output logic [7:0]             O_FLASH_DQ,
   output logic                   O_FLASH_DQ_OE
);
   if (ADDR_W != 20 && ADDR_W != 21) begin : g_bad_addr_w
      $error("ADDR_W must be 20 or 21");
   end
   if (ERASE_TMO_CYC < `PFCS_PROG_CYC || ERASE_TMO_CYC >= (1 << 24)) begin : g_bad_tmo
      $error("ERASE_TMO_CYC out of range");
   end

   pfcs_cyc_if #(.ADDR_W(ADDR_W)) cyc ();

   pfcs_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
      .i_clk   (I_SYS_CLK),
      .i_rst_n (I_RST_N),
      .cyc     (cyc),
      .o_ce_n  (O_FLASH_CE_N),
      .o_oe_n  (O_FLASH_OE_N),
      .o_we_n  (O_FLASH_WE_N),
      .o_addr  (O_FLASH_ADDR),
      .i_dq    (I_FLASH_DQ),
      .o_dq    (O_FLASH_DQ),
      .o_dq_oe (O_FLASH_DQ_OE)
   );

   // address and data byte of one step of a command sequence
   function automatic logic [ADDR_W+7:0] seq_word(input pfcs_op_type op,
                                                  input logic [2:0] step,
                                                  input logic [ADDR_W-1:0] addr,
                                                  input logic [7:0] data);
      logic [ADDR_W-1:0] a1;
      logic [ADDR_W-1:0] a2;
      a1 = ADDR_W'(`PFCS_UNLOCK_ADDR1);
      a2 = ADDR_W'(`PFCS_UNLOCK_ADDR2);
      unique case (step)
         3'd0: seq_word = {a1, `PFCS_UNLOCK_DATA1};
         3'd1: seq_word = {a2, `PFCS_UNLOCK_DATA2};
         3'd2: seq_word = {a1, (op == OP_PROG) ? `PFCS_PROG_CODE : `PFCS_ERASE_CODE};
         3'd3: seq_word = (op == OP_PROG) ? {addr, data} : {a1, `PFCS_UNLOCK_DATA1};
         3'd4: seq_word = {a2, `PFCS_UNLOCK_DATA2};
         default: begin
            unique case (op)
               OP_SECT:  seq_word = {addr[ADDR_W-1:`PFCS_SECT_LSB], 12'h000,
                                     `PFCS_SECT_CODE};
               OP_BLOCK: seq_word = {addr[ADDR_W-1:`PFCS_BLOCK_LSB], 16'h0000,
                                     `PFCS_BLOCK_CODE};
               default:  seq_word = {a1, `PFCS_CHIP_CODE};
            endcase
         end
      endcase
   endfunction : seq_word

   pfcs_seq_state_type state_reg, state_next;
   pfcs_op_type        op_reg, op_next;
   logic [ADDR_W-1:0]  addr_reg, addr_next;
   logic [7:0]         data_reg, data_next;
   logic [2:0]         step_reg, step_next;
   logic [7:0]         prev_reg, prev_next;
   logic               have_prev_reg, have_prev_next;
   logic               conf_reg, conf_next;
   logic [23:0]        tmo_reg, tmo_next;
   logic               done_reg, done_next, err_reg, err_next;
   logic [7:0]         rd_reg, rd_next;
   logic [ADDR_W+7:0]  word;
   logic [2:0]         last_step;
   logic [7:0]         expect_byte;
   logic               timed_out;

   assign word        = seq_word(op_reg, step_reg, addr_reg, data_reg);
   assign last_step   = (op_reg == OP_PROG) ? 3'(`PFCS_PROG_STEPS - 1) : 3'(`PFCS_ERASE_STEPS - 1);
   // program reads back the written byte, erases read back all ones
   assign expect_byte = (op_reg == OP_PROG) ? data_reg : `PFCS_ERASED;
   assign timed_out   = (op_reg == OP_PROG) ? (tmo_reg >= 24'(`PFCS_PROG_CYC))
                                            : (tmo_reg >= 24'(ERASE_TMO_CYC));

   always_comb begin
      state_next     = state_reg;
      op_next        = op_reg;
      addr_next      = addr_reg;
      data_next      = data_reg;
      step_next      = step_reg;
      prev_next      = prev_reg;
      have_prev_next = have_prev_reg;
      conf_next      = conf_reg;
      err_next       = err_reg;
      rd_next        = rd_reg;
      done_next      = 1'b0;
      tmo_next       = (state_reg == SEQ_POLL || state_reg == SEQ_CONFIRM) ? tmo_reg + 24'h1
                                                                           : 24'h0;
      unique case (state_reg)
         SEQ_IDLE: if (I_CMD_VALID && I_CMD_OP <= OP_CHIP) begin
            op_next        = I_CMD_OP;
            addr_next      = I_CMD_ADDR;
            data_next      = I_CMD_DATA;
            step_next      = 3'h0;
            have_prev_next = 1'b0;
            err_next       = 1'b0;
            state_next     = (I_CMD_OP == OP_READ) ? SEQ_READ : SEQ_WRITE;
         end
         SEQ_READ: if (cyc.done) begin
            rd_next    = cyc.rdata;
            done_next  = 1'b1;
            state_next = SEQ_IDLE;
         end
         SEQ_WRITE: if (cyc.done) begin
            if (step_reg == last_step) begin
               state_next = SEQ_POLL;
            end else begin
               step_next = step_reg + 3'h1;
            end
         end
         SEQ_POLL: if (cyc.done) begin
            prev_next      = cyc.rdata;
            have_prev_next = 1'b1;
            if (timed_out) begin
               err_next   = 1'b1;
               done_next  = 1'b1;
               state_next = SEQ_IDLE;
            end else if (have_prev_reg &&
                         cyc.rdata[`PFCS_TOGGLE_BIT] == prev_reg[`PFCS_TOGGLE_BIT]) begin
               conf_next  = 1'b0;
               state_next = SEQ_CONFIRM;
            end
         end
         SEQ_CONFIRM: if (cyc.done) begin
            if (timed_out) begin
               err_next   = 1'b1;
               done_next  = 1'b1;
               state_next = SEQ_IDLE;
            end else if (cyc.rdata == expect_byte) begin
               conf_next = 1'b1;
               if (conf_reg) begin
                  rd_next    = cyc.rdata;
                  done_next  = 1'b1;
                  state_next = SEQ_IDLE;
               end
            end else begin
               have_prev_next = 1'b0;
               state_next     = SEQ_POLL;
            end
         end
         default: state_next = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         state_reg     <= SEQ_IDLE;
         op_reg        <= OP_READ;
         addr_reg      <= '0;
         data_reg      <= 8'h00;
         step_reg      <= 3'h0;
         prev_reg      <= 8'h00;
         have_prev_reg <= 1'b0;
         conf_reg      <= 1'b0;
         tmo_reg       <= 24'h0;
         done_reg      <= 1'b0;
         err_reg       <= 1'b0;
         rd_reg        <= 8'h00;
      end else begin
         state_reg     <= state_next;
         op_reg        <= op_next;
         addr_reg      <= addr_next;
         data_reg      <= data_next;
         step_reg      <= step_next;
         prev_reg      <= prev_next;
         have_prev_reg <= have_prev_next;
         conf_reg      <= conf_next;
         tmo_reg       <= tmo_next;
         done_reg      <= done_next;
         err_reg       <= err_next;
         rd_reg        <= rd_next;
      end
   end

   // new commands wait until the running operation has finished
   assign O_CMD_READY = (state_reg == SEQ_IDLE);
   assign O_DONE      = done_reg;
   assign O_ERROR     = err_reg;
   assign O_RD_DATA   = rd_reg;
   assign cyc.req     = (state_reg != SEQ_IDLE);
   assign cyc.wr      = (state_reg == SEQ_WRITE);
   assign cyc.addr    = (state_reg == SEQ_WRITE) ? word[ADDR_W+7:8] : addr_reg;
   assign cyc.wdata   = word[7:0];

   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_N);

   unlock_first_a: assert property (cyc.wr && step_reg == 3'h0 |->
      cyc.addr == ADDR_W'(`PFCS_UNLOCK_ADDR1) && cyc.wdata == `PFCS_UNLOCK_DATA1)
      else $error("sequence does not open with the unlock write");
   busy_ready_a: assert property (state_reg == SEQ_POLL || state_reg == SEQ_CONFIRM |->
      !O_CMD_READY && !cyc.wr)
      else $error("write or command taken while flash busy");
   prog_len_a: assert property (op_reg == OP_PROG && cyc.wr && cyc.done |->
      step_reg <= 3'h3 ##1 (step_reg == 3'h3 || state_reg == SEQ_WRITE))
      else $error("program sequence length wrong");
   prog_final_a: assert property (op_reg == OP_PROG && cyc.wr && step_reg == 3'h3 |->
      cyc.addr == addr_reg && cyc.wdata == data_reg)
      else $error("program byte write carries wrong address or data");
   sect_final_a: assert property (op_reg == OP_SECT && cyc.wr && step_reg == 3'h5 |->
      cyc.wdata == `PFCS_SECT_CODE && cyc.addr[11:0] == 12'h000)
      else $error("sector erase final write wrong");
   block_final_a: assert property (op_reg == OP_BLOCK && cyc.wr && step_reg == 3'h5 |->
      cyc.wdata == `PFCS_BLOCK_CODE && cyc.addr[15:0] == 16'h0000)
      else $error("block erase final write wrong");
   chip_final_a: assert property (op_reg == OP_CHIP && cyc.wr && step_reg == 3'h5 |->
      cyc.wdata == `PFCS_CHIP_CODE && cyc.addr == ADDR_W'(`PFCS_UNLOCK_ADDR1))
      else $error("chip erase final write wrong");
   prog_tmo_a: assert property (op_reg == OP_PROG && state_reg == SEQ_POLL |->
      tmo_reg <= 24'(`PFCS_PROG_CYC + 64))
      else $error("program wait overran its limit");
   done_pulse_a: assert property (O_DONE |-> O_CMD_READY ##1 !O_DONE)
      else $error("done not a single pulse back to idle");

   prog_done_c: cover property (op_reg == OP_PROG && O_DONE && !O_ERROR);
   sect_done_c: cover property (op_reg == OP_SECT && O_DONE && !O_ERROR);
   read_done_c: cover property (op_reg == OP_READ && O_DONE);
   recheck_c:   cover property (state_reg == SEQ_CONFIRM ##1 state_reg == SEQ_POLL);
endmodule : pfcs_sequencer
`default_nettype wire

//--- verification/pfcs_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfcs_flash_model #(
   parameter int AW = 21
) (
   input  wire logic          i_ce_n,
   input  wire logic          i_oe_n,
   input  wire logic          i_we_n,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [7:0]    i_dq,
   input  wire logic          i_slow,
   input  wire logic          i_stuck,
   output logic [7:0]         o_dq,
   output int                 o_viol
);
   logic [7:0]    mem [int];
   logic [AW-1:0] la;
   logic [7:0]    val = 8'h00, pd = 8'h00;
   logic          drv = 1'b0, busy = 1'b0, prog = 1'b0, tog = 1'b0, lowpwr = 1'b0;
   int            step = 0, dur = 0;
   wire logic     wr_n = i_ce_n | i_we_n;
   wire logic     rd_n = i_ce_n | i_oe_n;
   initial o_viol = 0;
   function automatic logic [7:0] rdm(input logic [AW-1:0] a);
      return mem.exists(int'(a)) ? mem[int'(a)] : 8'hff;
   endfunction : rdm
   function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] d);
      return la == a && i_dq == d;
   endfunction : hit
   task automatic erase(input int sh);
      int q[$];
      foreach (mem[k]) begin
         if ((k >> sh) == (int'(la) >> sh)) q.push_back(k);
      end
      foreach (q[i]) mem.delete(q[i]);
      prog = 1'b0;
      dur = i_slow ? 30000 : 5000;
      busy = 1'b1;
   endtask : erase
   // stuck holds the operation open so the host's poll limit can be reached
   always @(posedge busy) begin
      #(dur);
      wait (!i_stuck);
      busy = 1'b0;
   end
   always @(negedge rd_n) begin
      lowpwr = 1'b0;
      #70;
      if (busy) begin
         tog = ~tog;
         val = {prog ? ~pd[7] : 1'b0, tog, ~pd[5:0]};
      end else begin
         val = rdm(i_addr);
      end
      drv = 1'b1;
   end
   always @(posedge rd_n) begin
      drv = 1'b0;
      lowpwr = 1'b1;
   end
   // released lines show the inverse of the last value, never a stale copy
   assign o_dq = drv ? val : ~val;
   always @(negedge wr_n) la = i_addr;
   always @(negedge i_we_n) begin
      if (i_ce_n === 1'b1) o_viol++;
   end
   always @(posedge wr_n) begin
      if (busy) begin
         o_viol++;
      end else begin
         case (step)
            0: step = hit(21'h05555, 8'haa) ? 1 : 0;
            1: step = hit(21'h02aaa, 8'h55) ? 2 : 0;
            2: step = hit(21'h05555, 8'ha0) ? 6 : hit(21'h05555, 8'h80) ? 3 : 0;
            3: step = hit(21'h05555, 8'haa) ? 4 : 0;
            4: step = hit(21'h02aaa, 8'h55) ? 5 : 0;
            5: begin
               step = 0;
               if (i_dq == 8'h30) erase(12);
               else if (i_dq == 8'h50) erase(16);
               else if (hit(21'h05555, 8'h10)) erase(AW);
            end
            default: begin
               step = 0;
               if (rdm(la) != 8'hff) o_viol++;
               mem[int'(la)] = rdm(la) & i_dq;
               pd = i_dq;
               prog = 1'b1;
               dur = i_slow ? 15000 : 2000;
               busy = 1'b1;
            end
         endcase
      end
   end
endmodule : pfcs_flash_model
`default_nettype wire

//--- verification/parallel_flash_command_sequencer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_flash_command_sequencer_tb_top import pfcs_pkg::*; ();
   logic        clk = 1'b0, rst_n = 1'b0, valid = 1'b0, slow = 1'b0, stuck = 1'b0;
   pfcs_op_type op = OP_READ;
   logic [20:0] addr = 21'h0, fa;
   logic [7:0]  wd = 8'h00, rdd, hdq, fdq, bus;
   logic        rdy, done, err, ce_n, oe_n, we_n, dq_oe;
   logic [31:0] seed = 32'h5681ad9d, r;
   logic [7:0]  ref_mem [int];
   int          failures = 0, cmp_count = 0, viol, lat;
   assign bus = dq_oe ? hdq : fdq;
   always #12.5 clk = ~clk;
   pfcs_sequencer #(.ADDR_W(21), .ERASE_TMO_CYC(2000)) dut (
      .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CMD_VALID(valid), .I_CMD_OP(op),
      .I_CMD_ADDR(addr), .I_CMD_DATA(wd), .O_CMD_READY(rdy), .O_DONE(done), .O_ERROR(err),
      .O_RD_DATA(rdd), .O_FLASH_CE_N(ce_n), .O_FLASH_OE_N(oe_n), .O_FLASH_WE_N(we_n),
      .O_FLASH_ADDR(fa), .I_FLASH_DQ(bus), .O_FLASH_DQ(hdq), .O_FLASH_DQ_OE(dq_oe));
   pfcs_flash_model #(.AW(21)) flash (
      .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(fa), .i_dq(bus),
      .i_slow(slow), .i_stuck(stuck), .o_dq(fdq), .o_viol(viol));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [7:0] expv(input logic [20:0] a);
      return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 8'hff;
   endfunction : expv
   task automatic summarize();
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task automatic bad(input string m);
      failures++;
      $display("Error at %0t: %s", $time, m);
   endtask : bad
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) bad($sformatf("byte %h, expected %h", got, exp));
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) bad($sformatf("flag %b, expected %b", got, exp));
   endtask : chk1
   task automatic chkn(input int got, input int exp);
      cmp_count++;
      if (got != exp) bad($sformatf("count %0d, expected %0d", got, exp));
   endtask : chkn
   // entered and left 2 ns after a clock edge
   task automatic cmd(input pfcs_op_type o, input logic [20:0] a, input logic [7:0] d,
                      input int lim);
      op = o;
      addr = a;
      wd = d;
      valid = 1'b1;
      @(posedge clk);
      #2;
      valid = 1'b0;
      for (lat = 1; lat <= lim; lat++) begin
         @(posedge clk);
         #1;
         if (lat == 1) chk1(rdy, 1'b0);
         if (done === 1'b1) break;
      end
      if (lat > lim) begin
         bad("no completion");
         summarize();
      end
      #1;
   endtask : cmd
   task automatic rd(input logic [20:0] a);
      cmd(OP_READ, a, 8'h00, 40);
      chkn(lat, 9);
      chk8(rdd, expv(a));
      chk1(flash.lowpwr, 1'b1);
   endtask : rd
   task automatic pg(input logic [20:0] a, input logic [7:0] d);
      cmd(OP_PROG, a, d, 3000);
      chk1(err, 1'b0);
      chk8(rdd, d);
      ref_mem[int'(a)] = d;
   endtask : pg
   task automatic er(input pfcs_op_type o, input int sh, input logic [20:0] a);
      int q[$];
      cmd(o, a, 8'h00, 2600);
      chk1(err, 1'b0);
      chk8(rdd, 8'hff);
      foreach (ref_mem[k]) begin
         if ((k >> sh) == (int'(a) >> sh)) q.push_back(k);
      end
      foreach (q[i]) ref_mem.delete(q[i]);
   endtask : er
   initial begin
      repeat (5) @(posedge clk);
      #2;
      chk1(rdy, 1'b1);
      chk1(ce_n, 1'b1);
      chk1(we_n, 1'b1);
      chk1(oe_n, 1'b1);
      chk1(dq_oe, 1'b0);
      chk8(hdq, 8'h00);
      chk1(fa == 21'h0, 1'b1);
      rst_n = 1'b1;
      @(posedge clk);
      #2;
      rd(21'h1fffff);
      for (int i = 0; i < 6; i++) begin
         r = xs();
         pg(r[20:0], r[28:21]);
         rd(r[20:0]);
         rd(r[20:0] ^ 21'h000001);
      end
      pg(21'h012345, 8'h00);
      pg(21'h013000, 8'h3c);
      er(OP_SECT, 12, 21'h012abc);
      rd(21'h012345);
      rd(21'h013000);
      pg(21'h0a0000, 8'h81);
      pg(21'h0affff, 8'h7e);
      pg(21'h0b0000, 8'h42);
      slow = 1'b1;
      er(OP_BLOCK, 16, 21'h0a8000);
      pg(21'h0c0101, 8'ha5);
      slow = 1'b0;
      rd(21'h0a0000);
      rd(21'h0affff);
      rd(21'h0b0000);
      stuck = 1'b1;
      cmd(OP_PROG, 21'h0d0202, 8'h96, 1200);
      chk1(err, 1'b1);
      stuck = 1'b0;
      ref_mem[int'(21'h0d0202)] = 8'h96;
      rd(21'h0d0202);
      op = pfcs_op_type'(3'h5);
      valid = 1'b1;
      repeat (15) begin
         @(posedge clk);
         #1;
         chk1(done, 1'b0);
         chk1(rdy, 1'b1);
         #1;
      end
      valid = 1'b0;
      @(posedge clk);
      #2;
      er(OP_CHIP, 21, 21'h005555);
      rd(21'h0b0000);
      rd(21'h0c0101);
      chkn(viol, 0);
      summarize();
   end
endmodule : parallel_flash_command_sequencer_tb_top
`default_nettype wire
